// ===== rtl/cmc_regs.svh
// register map constants for the clock multiplier configuration block
// assumes byte-wide registers on an 8-bit address
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH
`define CMC_OFS_REFRX 8'h11
`define CMC_OFS_CTRL0 8'h12
`define CMC_OFS_CTRL2 8'h14
`define CMC_OFS_CTRL3 8'h15
`define CMC_OFS_STAT0 8'h16
`define CMC_OFS_STAT1 8'h17
`define CMC_RST_REFRX 8'h5f
`define CMC_RST_CTRL0 8'h00
`define CMC_RST_CTRL2 8'he7
`define CMC_RST_CTRL3 8'hc9
`define CMC_MSK_REFRX 8'hff
`define CMC_MSK_CTRL0 8'hff
`define CMC_MSK_CTRL2 8'hff
`define CMC_MSK_CTRL3 8'hdf
`define CMC_BIT_DUTY 7
`define CMC_BIT_XADJ 5
`define CMC_BIT_PLLEN 7
`define CMC_BIT_MANUAL 6
`define CMC_BIT_LOCK 7
`define CMC_BIT_LOOPXP 4
`define CMC_FLD_XLEVEL 4:0
`define CMC_FLD_BAND 5:0
`define CMC_FLD_LOOPBW 7:5
`define CMC_FLD_PUMP 4:0
`define CMC_FLD_LDIV 7:6
`define CMC_FLD_ODIV 3:2
`define CMC_FLD_LRATIO 1:0
`define CMC_LOCK_NS 1000
`define CMC_CLK_NS 4
`define CMC_LOCK_CYC ((`CMC_LOCK_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

// ===== rtl/cmc_pkg.sv
// types for the clock multiplier configuration block
// assumes nothing beyond the register header
`default_nettype none
package cmc_pkg;
   typedef logic [7:0] cmc_byte_t;
   typedef enum logic [1:0] {CMC_OFF, CMC_SEARCH, CMC_SETTLE, CMC_LOCKED} cmc_state_t;
endpackage : cmc_pkg
`default_nettype wire

// ===== rtl/cmc_core.sv
// clock multiplier configuration registers and control outputs
// assumes a synchronous byte register port; status inputs come from the analog loop
// Function
// - reference receiver bit 7 enables duty correction, resets to zero.
// - reference receiver bit 5 enables crosspoint control, resets to zero.
// - bits 4:0 hold two's complement crosspoint level, reset 0x1F.
// - control 0 bit 7 enables multiplier, bit 6 selects manual band mode.
// - manual mode uses six-bit band field, 64 bands low to high.
// - control 2 bits 7:5 choose loop filter bandwidth, reset 0x7.
// - control 2 bits 4:0 set charge pump current, reset 0x07.
// - control 3 bits 7:6 divide reference by 2,4,8,16 for logic clock.
// - control 3 bit 4 enables loop divider crosspoint control, reset zero.
// - control 3 bits 3:2 give oscillator ratio 1,2,4,4, reset 0x2.
// - control 3 bits 1:0 give loop ratio 2,4,8,16, reset 0x1.
// - status bit 7 reports multiplier output stable, reset zero.
// - status bits 5:0 report the selected band, reset zero.
`include "cmc_regs.svh"
`default_nettype none
module cmc_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic regWr,
   input wire logic regRd,
   input wire cmc_pkg::cmc_byte_t regAddr,
   input wire cmc_pkg::cmc_byte_t regWdata,
   output cmc_pkg::cmc_byte_t regRdata,
   // loop status from analog side
   input wire logic loopLocked,
   input wire logic [5:0] autoBand,
   // reference receiver controls
   output logic ref_duty_fix_on,
   output logic ref_cross_adjust_on,
   output logic [4:0] ref_cross_level,
   // multiplier controls and status
   output logic pllEnable,
   output logic manualBandSel,
   output logic [5:0] oscBand,
   output logic [2:0] loop_filter_width,
   output logic [4:0] pump_current_code,
   output logic [4:0] logic_clock_divide,
   output logic loopCrossOn,
   output logic [2:0] oscillator_divide,
   output logic [4:0] loopRatio,
   output logic logicClkEn,
   output logic pllStable
);
   import cmc_pkg::*;

   logic rstSync1_ff, rstSync2_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   cmc_byte_t refRx_ff, ctrl0_ff, ctrl2_ff, ctrl3_ff, rdata_ff;
   cmc_byte_t nxt_refRx, nxt_ctrl0, nxt_ctrl2, nxt_ctrl3, nxt_rdata;
   cmc_state_t state_ff, nxt_state;
   logic [15:0] settle_ff, nxt_settle;
   logic [3:0] div_ff, nxt_div;
   logic [5:0] band_ff, nxt_band;
   logic lock_ff, nxt_lock;
   logic [3:0] divMask;
   logic [2:0] oscDiv;

   // reserved bit 6 stored as written; software is expected to keep it 1
   always_comb begin
      nxt_refRx = refRx_ff;
      nxt_ctrl0 = ctrl0_ff;
      nxt_ctrl2 = ctrl2_ff;
      nxt_ctrl3 = ctrl3_ff;
      if (regWr) begin
         case (regAddr)
            `CMC_OFS_REFRX: nxt_refRx = regWdata & `CMC_MSK_REFRX;
            `CMC_OFS_CTRL0: nxt_ctrl0 = regWdata & `CMC_MSK_CTRL0;
            `CMC_OFS_CTRL2: nxt_ctrl2 = regWdata & `CMC_MSK_CTRL2;
            `CMC_OFS_CTRL3: nxt_ctrl3 = regWdata & `CMC_MSK_CTRL3;
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = rdata_ff;
      if (regRd) begin
         case (regAddr)
            `CMC_OFS_REFRX: nxt_rdata = refRx_ff;
            `CMC_OFS_CTRL0: nxt_rdata = ctrl0_ff;
            `CMC_OFS_CTRL2: nxt_rdata = ctrl2_ff;
            `CMC_OFS_CTRL3: nxt_rdata = ctrl3_ff;
            `CMC_OFS_STAT0: nxt_rdata = {lock_ff, 7'h00};
            `CMC_OFS_STAT1: nxt_rdata = {2'h0, band_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // lock tracking: manual mode takes the programmed band, auto follows the loop
   always_comb begin
      nxt_state = state_ff;
      nxt_settle = settle_ff;
      nxt_band = band_ff;
      nxt_lock = 1'b0;
      case (state_ff)
         CMC_OFF: begin
            nxt_band = 6'h00;
            if (ctrl0_ff[`CMC_BIT_PLLEN]) begin
               nxt_state = CMC_SEARCH;
            end
         end
         CMC_SEARCH: begin
            nxt_band = ctrl0_ff[`CMC_BIT_MANUAL] ? ctrl0_ff[`CMC_FLD_BAND] : autoBand;
            nxt_settle = 16'h0000;
            nxt_state = CMC_SETTLE;
         end
         CMC_SETTLE: begin
            nxt_band = ctrl0_ff[`CMC_BIT_MANUAL] ? ctrl0_ff[`CMC_FLD_BAND] : autoBand;
            // lock must hold for a full settle window before reporting it
            if (!loopLocked) begin
               nxt_settle = 16'h0000;
            end else if (settle_ff >= 16'(`CMC_LOCK_CYC - 1)) begin
               nxt_state = CMC_LOCKED;
            end else begin
               nxt_settle = settle_ff + 16'h0001;
            end
         end
         CMC_LOCKED: begin
            nxt_lock = loopLocked;
            nxt_band = ctrl0_ff[`CMC_BIT_MANUAL] ? ctrl0_ff[`CMC_FLD_BAND] : autoBand;
            if (!loopLocked) begin
               nxt_state = CMC_SEARCH;
            end
         end
         default: nxt_state = CMC_OFF;
      endcase
      if (!ctrl0_ff[`CMC_BIT_PLLEN]) begin
         nxt_state = CMC_OFF;
         nxt_lock = 1'b0;
      end
   end

   // logic clock enable: one pulse every 2,4,8,16 cycles
   always_comb begin
      divMask = 4'((5'h02 << ctrl3_ff[`CMC_FLD_LDIV]) - 5'h01);
      nxt_div = ((div_ff & divMask) == divMask) ? 4'h0 : div_ff + 4'h1;
   end

   // oscillator ratio: codes 10 and 11 both give four
   always_comb begin
      case (ctrl3_ff[`CMC_FLD_ODIV])
         2'b00: oscDiv = 3'h1;
         2'b01: oscDiv = 3'h2;
         default: oscDiv = 3'h4;
      endcase
   end

   // control registers
   always_ff @(posedge clk or negedge rstSync2_ff) begin
      if (!rstSync2_ff) begin
         refRx_ff <= `CMC_RST_REFRX;
         ctrl0_ff <= `CMC_RST_CTRL0;
         ctrl2_ff <= `CMC_RST_CTRL2;
         ctrl3_ff <= `CMC_RST_CTRL3;
      end else begin
         refRx_ff <= nxt_refRx;
         ctrl0_ff <= nxt_ctrl0;
         ctrl2_ff <= nxt_ctrl2;
         ctrl3_ff <= nxt_ctrl3;
      end
   end

   // read data holds until the next read
   always_ff @(posedge clk or negedge rstSync2_ff) begin
      if (!rstSync2_ff) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // lock tracking state
   always_ff @(posedge clk or negedge rstSync2_ff) begin
      if (!rstSync2_ff) begin
         state_ff <= CMC_OFF;
         settle_ff <= 16'h0000;
         band_ff <= 6'h00;
         lock_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         settle_ff <= nxt_settle;
         band_ff <= nxt_band;
         lock_ff <= nxt_lock;
      end
   end

   // logic clock divider
   always_ff @(posedge clk or negedge rstSync2_ff) begin
      if (!rstSync2_ff) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   // ratio choice against the logic clock limit is left to software
   assign logicClkEn = ((div_ff & divMask) == divMask);
   assign regRdata = rdata_ff;
   assign ref_duty_fix_on = refRx_ff[`CMC_BIT_DUTY];
   assign ref_cross_adjust_on = refRx_ff[`CMC_BIT_XADJ];
   assign ref_cross_level = refRx_ff[`CMC_FLD_XLEVEL];
   assign pllEnable = ctrl0_ff[`CMC_BIT_PLLEN];
   assign manualBandSel = ctrl0_ff[`CMC_BIT_MANUAL];
   assign oscBand = band_ff;
   assign loop_filter_width = ctrl2_ff[`CMC_FLD_LOOPBW];
   assign pump_current_code = ctrl2_ff[`CMC_FLD_PUMP];
   assign logic_clock_divide = 5'(5'h02 << ctrl3_ff[`CMC_FLD_LDIV]);
   assign loopCrossOn = ctrl3_ff[`CMC_BIT_LOOPXP];
   assign oscillator_divide = oscDiv;
   assign loopRatio = 5'(5'h02 << ctrl3_ff[`CMC_FLD_LRATIO]);
   assign pllStable = lock_ff;
endmodule : cmc_core
`default_nettype wire

// ===== tb/cmc_checker.sv
// assertions for the clock multiplier configuration block
// assumes it is bound onto cmc_core and sees only its ports
`default_nettype none
module cmc_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic regWr,
   input wire logic regRd,
   input wire cmc_pkg::cmc_byte_t regAddr,
   input wire cmc_pkg::cmc_byte_t regWdata,
   input wire cmc_pkg::cmc_byte_t regRdata,
   // loop status
   input wire logic loopLocked,
   // controls and status
   input wire logic ref_duty_fix_on,
   input wire logic ref_cross_adjust_on,
   input wire logic [4:0] ref_cross_level,
   input wire logic pllEnable,
   input wire logic manualBandSel,
   input wire logic [5:0] oscBand,
   input wire logic [2:0] loop_filter_width,
   input wire logic [4:0] pump_current_code,
   input wire logic [4:0] logic_clock_divide,
   input wire logic loopCrossOn,
   input wire logic [2:0] oscillator_divide,
   input wire logic [4:0] loopRatio,
   input wire logic pllStable
);
   import cmc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic wr3 = regWr && regAddr == 8'h15;
   a_refrx_write: assert property (regWr && regAddr == 8'h11 |=>
      {ref_duty_fix_on, ref_cross_adjust_on, ref_cross_level} == {$past(regWdata[7]), $past(regWdata[5:0])})
      else $error("receiver fields");
   a_ctrl0_write: assert property (regWr && regAddr == 8'h12 |=> {pllEnable, manualBandSel} == $past(regWdata[7:6]))
      else $error("enable or mode");
   a_loop_write: assert property (regWr && regAddr == 8'h14 |=>
      {loop_filter_width, pump_current_code} == $past(regWdata)) else $error("loop fields");
   a_divide_decode: assert property (wr3 |=> logic_clock_divide == 5'd2 << $past(regWdata[7:6]) &&
      loopRatio == 5'd2 << $past(regWdata[1:0])) else $error("divide ratios");
   a_osc_decode: assert property (wr3 |=> loopCrossOn == $past(regWdata[4]) &&
      oscillator_divide == ($past(regWdata[3]) ? 3'd4 : 3'd1 << $past(regWdata[2]))) else $error("osc ratio");
   a_lock_drop: assert property ($fell(loopLocked) |-> ##[1:2] !pllStable) else $error("stale lock");
   a_status_read: assert property (regRd && regAddr == 8'h16 |=> regRdata == {$past(pllStable), 7'h00})
      else $error("status read");
   a_band_read: assert property (regRd && regAddr == 8'h17 |=> regRdata == {2'h0, $past(oscBand)})
      else $error("band read");
   a_unmapped_read: assert property (regRd && !(regAddr inside {[8'h11:8'h12], [8'h14:8'h17]}) |=>
      regRdata == 8'h00) else $error("unmapped read");
endmodule : cmc_checker
bind cmc_core cmc_checker u_chk (.clk, .rst_b, .regWr, .regRd, .loopLocked, .regAddr, .regWdata, .regRdata,
   .ref_duty_fix_on, .ref_cross_adjust_on, .pllEnable, .manualBandSel, .loopCrossOn, .pllStable, .oscBand,
   .ref_cross_level, .pump_current_code, .logic_clock_divide, .loopRatio, .loop_filter_width, .oscillator_divide);
`default_nettype wire

// ===== tb/tb_cmc_core.sv
// self-checking bench for the clock multiplier configuration block
// assumes cmc_core with the checker bound onto it
`default_nettype none
module tb_cmc_core;
   timeunit 1ns;
   timeprecision 1ps;
   import cmc_pkg::*;
   logic clk, rst_b, regWr, regRd, loopLocked, ref_duty_fix_on, ref_cross_adjust_on, pllEnable, manualBandSel;
   logic loopCrossOn, logicClkEn, pllStable;
   logic [5:0] autoBand, oscBand;
   logic [4:0] ref_cross_level, pump_current_code, logic_clock_divide, loopRatio;
   logic [2:0] loop_filter_width, oscillator_divide;
   cmc_byte_t regAddr, regWdata, regRdata, d;
   cmc_byte_t sh [4] = '{8'h5f, 8'h00, 8'he7, 8'hc9};
   cmc_byte_t ofs [4] = '{8'h11, 8'h12, 8'h14, 8'h15};
   int badCount = 0, checkCount = 0, cyc = 0, k, n;
   int pt [3];
   cmc_core dut (.clk, .rst_b, .regWr, .regRd, .regAddr, .regWdata, .regRdata, .loopLocked, .autoBand,
      .ref_duty_fix_on, .ref_cross_adjust_on, .ref_cross_level, .pllEnable, .manualBandSel, .oscBand,
      .loop_filter_width, .pump_current_code, .logic_clock_divide, .loopCrossOn, .oscillator_divide, .loopRatio,
      .logicClkEn, .pllStable);
   task automatic tallyAndFinish();
      if (badCount == 0 && checkCount > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tallyAndFinish
   task automatic chk(input cmc_byte_t got, input cmc_byte_t exp);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("Error %0t: saw %h want %h", $time, got, exp);
      end
   endtask : chk
   // second edge before returning so a strobe is never set twice in one step
   task automatic wr(input cmc_byte_t a, input cmc_byte_t v);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input cmc_byte_t a, input cmc_byte_t exp);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
      @(posedge clk);
   endtask : rd
   // reserved bit 5 of the divider register never stores
   function automatic cmc_byte_t expRd(int j, cmc_byte_t v);
      return (j == 3) ? (v & 8'hdf) : v;
   endfunction : expRd
   // logic clock period in reference cycles for a divide code
   function automatic cmc_byte_t expPeriod(int c);
      return 8'(2 << c);
   endfunction : expPeriod
   task automatic chkAll();
      for (int j = 0; j < 4; j++) rd(ofs[j], sh[j]);
      chk({ref_duty_fix_on, 1'b0, ref_cross_adjust_on, ref_cross_level}, sh[0] & 8'hbf);
      chk({pllEnable, manualBandSel, 6'h00}, sh[1] & 8'hc0);
      chk({loop_filter_width, pump_current_code}, sh[2]);
      chk({3'h0, logic_clock_divide}, 8'h02 << sh[3][7:6]);
      chk({loopCrossOn, 4'h0, oscillator_divide}, {sh[3][4], 4'h0, sh[3][3] ? 3'h4 : (3'h1 << sh[3][2])});
      chk({3'h0, loopRatio}, 8'h02 << sh[3][1:0]);
   endtask : chkAll
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         badCount++;
         tallyAndFinish();
      end
   end
   initial begin
      {rst_b, regWr, regRd, loopLocked} = 4'h0;
      {autoBand, regAddr, regWdata} = 22'h0;
      k = $urandom(32'hed6406d2);
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chkAll();
      chk({pllStable, 1'b0, oscBand}, 8'h00);
      for (int i = 0; i < 30; i++) begin
         k = (i < 2) ? 3 : int'($urandom_range(3, 0));
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         if (k == 0) d[6] = 1'b1;
         wr(ofs[k], d);
         sh[k] = expRd(k, d);
         chkAll();
      end
      wr(8'h13, 8'hff);
      wr(8'h16, 8'hff);
      rd(8'h13, 8'h00);
      rd(8'h16, 8'h00);
      chkAll();
      // code 00 skipped: at this reference rate it would break the logic clock limit
      for (int c = 1; c < 4; c++) begin
         d = {2'(c), 6'($urandom)} & 8'hdf;
         wr(8'h15, d);
         sh[3] = d;
         pt = '{0, 0, 0};
         n = 0;
         for (int t = 0; t < 48 && n < 3; t++) begin
            @(negedge clk);
            if (logicClkEn === 1'b1) begin
               pt[n] = t;
               n++;
            end
         end
         @(posedge clk);
         chk(8'(pt[2] - pt[1]), expPeriod(c));
         chkAll();
      end
      d = 8'($urandom) & 8'h3f;
      autoBand <= 6'($urandom);
      loopLocked <= 1'b1;
      wr(8'h12, 8'hc0 | d);
      for (k = 0; k < 400 && pllStable !== 1'b1; k++) @(posedge clk);
      rd(8'h16, 8'h80);
      rd(8'h17, d);
      #1 chk({2'h0, oscBand}, d);
      @(posedge clk);
      wr(8'h12, 8'h80);
      repeat (4) @(posedge clk);
      #1 chk({2'h0, oscBand}, {2'h0, autoBand});
      @(posedge clk);
      loopLocked <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk({7'h0, pllStable}, 8'h00);
      tallyAndFinish();
   end
endmodule : tb_cmc_core
`default_nettype wire
